// ### design/kme_pkg.sv
package kme_pkg;
   localparam int unsigned CLK_HZ           = 200_000_000;
   localparam int unsigned OSC_HZ           = 4_000_000;
   localparam int unsigned KEY_CYCLE_MS     = 50;
   localparam int unsigned TONE_MS          = 45;
   localparam int unsigned REPEAT_DELAY_MS  = 660;
   localparam int unsigned REPEAT_PERIOD_MS = 204;
   localparam int unsigned TONE_HZ          = 1000;
   localparam int unsigned VALID_DELAY_NS   = 1000;
   localparam int unsigned BAUD_LOW         = 2400;
   localparam int unsigned BAUD_HIGH        = 9600;
   localparam int unsigned KEY_CYCLE_CYC     = (CLK_HZ / 1000) * KEY_CYCLE_MS;
   localparam int unsigned TONE_CYC          = (CLK_HZ / 1000) * TONE_MS;
   localparam int unsigned REPEAT_DELAY_CYC  = (CLK_HZ / 1000) * REPEAT_DELAY_MS;
   localparam int unsigned REPEAT_PERIOD_CYC = (CLK_HZ / 1000) * REPEAT_PERIOD_MS;
   localparam int unsigned TONE_HALF_CYC     = CLK_HZ / (2 * TONE_HZ);
   localparam int unsigned VALID_DELAY_CYC   = (VALID_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned BIT_CYC_LOW       = CLK_HZ / BAUD_LOW;
   localparam int unsigned BIT_CYC_HIGH      = CLK_HZ / BAUD_HIGH;
   localparam int unsigned SCAN_SETTLE_CYC   = 4;
   localparam int unsigned CNT_W             = 32;
   localparam int unsigned ROWS              = 4;
   localparam int unsigned COLS              = 4;
   localparam int unsigned KEY_W             = 4;
   localparam logic [3:0]  IDLE_ROWS         = 4'hf;
   localparam logic [3:0]  FIRST_ROW         = 4'h1;
   localparam logic [1:0]  LAST_ROW_IDX      = 2'h3;
   localparam logic [3:0]  DECIMAL_KEYS      = 4'ha;
   localparam logic [7:0]  ASCII_DIGIT_OFS   = 8'h30;
   localparam logic [7:0]  ASCII_ALPHA_OFS   = 8'h37;
   localparam logic [3:0]  FRAME_BITS        = 4'ha;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SCAN_DRIVE,
      ST_SCAN_SAMPLE,
      ST_PRESENT,
      ST_TONE,
      ST_SEND,
      ST_PAD,
      ST_HOLD
   } kme_state_t;
endpackage

// ### design/kme_tone.sv
`timescale 1ns/1ps
module kme_tone
   import kme_pkg::*;
#(
   parameter int unsigned HALF_CYC = TONE_HALF_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic en,
   output logic      tone_out
);
   logic [CNT_W-1:0] div_reg;
   logic [CNT_W-1:0] div_next;
   logic             tone_reg;
   logic             tone_next;

   // square wave, forced low the cycle after en drops and held low while disabled
   always_comb begin
      div_next  = div_reg;
      tone_next = tone_reg;
      if (!en) begin
         div_next  = '0;
         tone_next = 1'b0;
      end else if (div_reg == HALF_CYC - 1) begin
         div_next  = '0;
         tone_next = !tone_reg;
      end else begin
         div_next = div_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg  <= '0;
         tone_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tone_reg <= tone_next;
      end
   end

   assign tone_out = tone_reg;

   property p_tone_quiet;
      @(posedge clk) disable iff (rst) !en |=> !tone_reg;
   endproperty
   a_tone_quiet: assert property (p_tone_quiet) else $error("tone active while disabled");
endmodule

// ### design/kme_top.sv
`timescale 1ns/1ps
module kme_top
   import kme_pkg::*;
#(
   parameter int unsigned CYCLE_CYC  = KEY_CYCLE_CYC,
   parameter int unsigned TONE_LEN   = TONE_CYC,
   parameter int unsigned DELAY_CYC  = REPEAT_DELAY_CYC,
   parameter int unsigned PERIOD_CYC = REPEAT_PERIOD_CYC,
   parameter int unsigned HALF_CYC   = TONE_HALF_CYC,
   parameter int unsigned BIT_LOW    = BIT_CYC_LOW,
   parameter int unsigned BIT_HIGH   = BIT_CYC_HIGH
) (
   input  wire logic             SYS_CLK,
   input  wire logic             RST,
   input  wire logic [COLS-1:0]  COL_SENSE,
   input  wire logic             BAUD_SEL,
   output logic      [ROWS-1:0]  ROW_DRIVE,
   output logic                  VALID_N,
   output logic                  BEEP_OUT,
   output logic                  SERIAL_TX_OUT
);
   kme_state_t       state_reg;
   kme_state_t       state_next;
   logic [3:0]       row_drv_reg;
   logic [3:0]       row_drv_next;
   logic [3:0]       key_reg;
   logic [3:0]       key_next;
   logic [1:0]       row_idx_reg;
   logic [1:0]       row_idx_next;
   logic [CNT_W-1:0] step_reg;
   logic [CNT_W-1:0] step_next;
   logic [CNT_W-1:0] cyc_reg;
   logic [CNT_W-1:0] cyc_next;
   logic [CNT_W-1:0] hold_target;
   logic             valid_n_reg;
   logic             valid_n_next;
   logic             repeat_reg;
   logic             repeat_next;
   logic             tone_en_reg;
   logic             tone_en_next;
   logic             tx_start_reg;
   logic             tx_start_next;
   logic             tx_busy;
   logic [7:0]       ascii_byte;
   logic [1:0]       hit_col;
   logic             any_col;

   // lowest closed column wins; unused columns sit pulled low
   always_comb begin
      hit_col = '0;
      for (int i = COLS - 1; i >= 0; i--) begin
         if (COL_SENSE[i]) begin
            hit_col = 2'(i);
         end
      end
   end

   assign any_col     = |COL_SENSE;
   assign hold_target = repeat_reg ? PERIOD_CYC : DELAY_CYC;

   assign ascii_byte = (key_reg < DECIMAL_KEYS) ? ({4'h0, key_reg} + ASCII_DIGIT_OFS)
                                                : ({4'h0, key_reg} + ASCII_ALPHA_OFS);

   always_comb begin
      state_next    = state_reg;
      row_drv_next  = row_drv_reg;
      key_next      = key_reg;
      row_idx_next  = row_idx_reg;
      step_next     = step_reg + 1'b1;
      cyc_next      = cyc_reg + 1'b1;
      valid_n_next  = valid_n_reg;
      repeat_next   = repeat_reg;
      tone_en_next  = tone_en_reg;
      tx_start_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            row_drv_next = IDLE_ROWS;
            valid_n_next = 1'b1;
            cyc_next     = '0;
            repeat_next  = 1'b0;
            if (any_col) begin
               state_next   = ST_SCAN_DRIVE;
               row_idx_next = '0;
               row_drv_next = FIRST_ROW;
               step_next    = '0;
            end
         end
         ST_SCAN_DRIVE: begin
            if (step_reg == SCAN_SETTLE_CYC - 1) begin
               state_next = ST_SCAN_SAMPLE;
            end
         end
         ST_SCAN_SAMPLE: begin
            step_next = '0;
            if (any_col) begin
               key_next     = {row_idx_reg, hit_col};
               row_drv_next = {row_idx_reg, hit_col};
               state_next   = ST_PRESENT;
            end else if (row_idx_reg == LAST_ROW_IDX) begin
               row_drv_next = IDLE_ROWS;
               state_next   = ST_IDLE;
            end else begin
               row_idx_next = row_idx_reg + 1'b1;
               row_drv_next = FIRST_ROW << (row_idx_reg + 1'b1);
               state_next   = ST_SCAN_DRIVE;
            end
         end
         ST_PRESENT: begin
            if (step_reg == VALID_DELAY_CYC - 1) begin
               valid_n_next = 1'b0;
               tone_en_next = 1'b1;
               step_next    = '0;
               state_next   = ST_TONE;
            end
         end
         ST_TONE: begin
            if (step_reg == TONE_LEN - 1) begin
               tone_en_next  = 1'b0;
               tx_start_next = 1'b1;
               state_next    = ST_SEND;
            end
         end
         ST_SEND: begin
            if (!tx_busy && !tx_start_reg) begin
               state_next = ST_PAD;
            end
         end
         ST_PAD: begin
            if (cyc_reg >= CYCLE_CYC - 1) begin
               valid_n_next = 1'b1;
               row_drv_next = IDLE_ROWS;
               state_next   = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!any_col) begin
               state_next = ST_IDLE;
            end else if (cyc_reg >= hold_target - 1) begin
               repeat_next  = 1'b1;
               cyc_next     = '0;
               step_next    = '0;
               row_idx_next = '0;
               row_drv_next = FIRST_ROW;
               state_next   = ST_SCAN_DRIVE;
            end
         end
         default: begin
            state_next   = ST_IDLE;
            row_drv_next = IDLE_ROWS;
            valid_n_next = 1'b1;
            tone_en_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_reg    <= ST_IDLE;
         row_drv_reg  <= IDLE_ROWS;
         key_reg      <= '0;
         row_idx_reg  <= '0;
         step_reg     <= '0;
         cyc_reg      <= '0;
         valid_n_reg  <= 1'b1;
         repeat_reg   <= 1'b0;
         tone_en_reg  <= 1'b0;
         tx_start_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         row_drv_reg  <= row_drv_next;
         key_reg      <= key_next;
         row_idx_reg  <= row_idx_next;
         step_reg     <= step_next;
         cyc_reg      <= cyc_next;
         valid_n_reg  <= valid_n_next;
         repeat_reg   <= repeat_next;
         tone_en_reg  <= tone_en_next;
         tx_start_reg <= tx_start_next;
      end
   end

   kme_tone #(
      .HALF_CYC (HALF_CYC)
   ) u_tone (
      .clk      (SYS_CLK),
      .rst      (RST),
      .en       (tone_en_reg),
      .tone_out (BEEP_OUT)
   );

   kme_uart_tx #(
      .BIT_LOW  (BIT_LOW),
      .BIT_HIGH (BIT_HIGH)
   ) u_uart (
      .clk       (SYS_CLK),
      .rst       (RST),
      .baud_high (BAUD_SEL),
      .start     (tx_start_reg),
      .data      (ascii_byte),
      .busy      (tx_busy),
      .tx        (SERIAL_TX_OUT)
   );

   assign ROW_DRIVE = row_drv_reg;
   assign VALID_N   = valid_n_reg;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   sequence s_strobe_falls;
      $fell(VALID_N);
   endsequence
   sequence s_line_quiet;
      SERIAL_TX_OUT [*8];
   endsequence
   sequence s_strobe_held;
      !VALID_N [*8];
   endsequence

   property p_idle_rows;
      (state_reg == ST_IDLE) |-> (ROW_DRIVE == IDLE_ROWS);
   endproperty
   a_idle_rows: assert property (p_idle_rows) else $error("rows not high while idle");

   property p_scan_onehot;
      (state_reg == ST_SCAN_DRIVE) |-> $onehot(ROW_DRIVE);
   endproperty
   a_scan_onehot: assert property (p_scan_onehot) else $error("scan drives more than one row");

   property p_code_on_rows;
      !VALID_N |-> (ROW_DRIVE == key_reg);
   endproperty
   a_code_on_rows: assert property (p_code_on_rows) else $error("rows differ from key while valid");

   property p_key_formula;
      (state_reg == ST_SCAN_SAMPLE && any_col) |=> ($past(ROW_DRIVE) == (FIRST_ROW << key_reg[3:2]))
                                                    && ((($past(COL_SENSE) >> key_reg[1:0]) & 4'h1) == 4'h1)
                                                    && (($past(COL_SENSE) & ((4'h1 << key_reg[1:0]) - 4'h1)) == 4'h0);
   endproperty
   a_key_formula: assert property (p_key_formula) else $error("key not row times four plus column");

   property p_ascii;
      tx_start_reg |-> (ascii_byte == ((key_reg < DECIMAL_KEYS) ? 8'h30 + {4'h0, key_reg}
                                                                  : 8'h37 + {4'h0, key_reg}));
   endproperty
   a_ascii: assert property (p_ascii) else $error("serial byte not ascii hex digit");

   property p_strobe_first;
      s_strobe_falls |-> s_line_quiet;
   endproperty
   a_strobe_first: assert property (p_strobe_first) else $error("serial began with the strobe");

   property p_send_while_valid;
      tx_start_reg |-> (!VALID_N && !tone_en_reg && $past(tone_en_reg));
   endproperty
   a_send_while_valid: assert property (p_send_while_valid) else $error("byte sent outside key cycle");

   property p_strobe_stands;
      s_strobe_falls |-> s_strobe_held;
   endproperty
   a_strobe_stands: assert property (p_strobe_stands) else $error("strobe released early");

   property p_hold_cleared;
      (state_reg == ST_HOLD) |-> (VALID_N && ROW_DRIVE == IDLE_ROWS && !BEEP_OUT);
   endproperty
   a_hold_cleared: assert property (p_hold_cleared) else $error("outputs not cleared while held");

   property p_rows_frozen;
      (!VALID_N && !$past(VALID_N)) |-> $stable(ROW_DRIVE);
   endproperty
   a_rows_frozen: assert property (p_rows_frozen) else $error("code moved while strobe low");

   property p_scan_strobe_high;
      (state_reg == ST_SCAN_DRIVE || state_reg == ST_SCAN_SAMPLE) |-> VALID_N;
   endproperty
   a_scan_strobe_high: assert property (p_scan_strobe_high) else $error("strobe low during scan");

   property p_tone_line_quiet;
      tone_en_reg |-> (SERIAL_TX_OUT && !tx_busy);
   endproperty
   a_tone_line_quiet: assert property (p_tone_line_quiet) else $error("serial active during tone");

   property p_cycle_length;
      ($rose(VALID_N) && !$past(RST)) |-> (cyc_reg == CYCLE_CYC);
   endproperty
   a_cycle_length: assert property (p_cycle_length) else $error("key cycle length wrong");
endmodule

// ### design/kme_uart_tx.sv
`timescale 1ns/1ps
module kme_uart_tx
   import kme_pkg::*;
#(
   parameter int unsigned BIT_LOW  = BIT_CYC_LOW,
   parameter int unsigned BIT_HIGH = BIT_CYC_HIGH
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       baud_high,
   input  wire logic       start,
   input  wire logic [7:0] data,
   output logic            busy,
   output logic            tx
);
   logic [CNT_W-1:0] div_reg;
   logic [CNT_W-1:0] div_next;
   logic [CNT_W-1:0] bit_cyc;
   logic [9:0]       shift_reg;
   logic [9:0]       shift_next;
   logic [3:0]       cnt_reg;
   logic [3:0]       cnt_next;
   logic             busy_reg;
   logic             busy_next;
   logic             tx_reg;
   logic             tx_next;
   logic             fast_reg;
   logic             fast_next;

   assign bit_cyc = fast_reg ? BIT_HIGH : BIT_LOW;

   always_comb begin
      div_next   = div_reg;
      shift_next = shift_reg;
      cnt_next   = cnt_reg;
      busy_next  = busy_reg;
      tx_next    = tx_reg;
      fast_next  = fast_reg;
      if (!busy_reg) begin
         tx_next = 1'b1;
         if (start) begin
            shift_next = {1'b1, data, 1'b0};
            cnt_next   = FRAME_BITS;
            div_next   = '0;
            busy_next  = 1'b1;
            fast_next  = baud_high;
         end
      end else if (div_reg == '0) begin
         if (cnt_reg == '0) begin
            busy_next = 1'b0;
            tx_next   = 1'b1;
         end else begin
            tx_next    = shift_reg[0];
            shift_next = {1'b1, shift_reg[9:1]};
            cnt_next   = cnt_reg - 1'b1;
            div_next   = bit_cyc - 1'b1;
         end
      end else begin
         div_next = div_reg - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg   <= '0;
         shift_reg <= '1;
         cnt_reg   <= '0;
         busy_reg  <= 1'b0;
         tx_reg    <= 1'b1;
         fast_reg  <= 1'b0;
      end else begin
         div_reg   <= div_next;
         shift_reg <= shift_next;
         cnt_reg   <= cnt_next;
         busy_reg  <= busy_next;
         tx_reg    <= tx_next;
         fast_reg  <= fast_next;
      end
   end

   assign busy = busy_reg;
   assign tx   = tx_reg;

   property p_line_idle;
      @(posedge clk) disable iff (rst) !busy_reg |-> tx_reg;
   endproperty
   a_line_idle: assert property (p_line_idle) else $error("line not at mark while idle");

   property p_start_bit;
      @(posedge clk) disable iff (rst) (start && !busy_reg) |=> ##1 !tx_reg;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("frame did not open with start bit");
endmodule

// ### verif/kme_keypad_model.sv
`timescale 1ns/1ps
module kme_keypad_model
   import kme_pkg::*;
(
   input  wire logic [ROWS-1:0] row_drive,
   input  wire logic [15:0]     held,
   output logic      [COLS-1:0] col_sense
);
   // a closed key joins its row to its column; open columns sit at the pull-down level
   always_comb begin
      for (int c = 0; c < COLS; c++) begin
         col_sense[c] = 1'b0;
         for (int r = 0; r < ROWS; r++) begin
            col_sense[c] = col_sense[c] | (held[r*COLS+c] & row_drive[r]);
         end
      end
   end
endmodule

// ### verif/tb_keypad_matrix_encoder.sv
`timescale 1ns/1ps
module tb_keypad_matrix_encoder;
   import kme_pkg::*;
   localparam int T_CYC  = 3000;
   localparam int T_TONE = 1000;
   localparam int T_DLY  = 8000;
   localparam int T_PER  = 5000;
   localparam int T_HALF = 50;
   localparam int T_BL   = 64;
   localparam int T_BH   = 16;
   logic        SYS_CLK;
   logic        RST;
   logic        BAUD_SEL;
   logic [3:0]  COL_SENSE;
   logic [3:0]  ROW_DRIVE;
   logic        VALID_N;
   logic        BEEP_OUT;
   logic        SERIAL_TX_OUT;
   logic [15:0] held;
   int          n_fail;
   int          checks;
   int          cyc;

   kme_top #(.CYCLE_CYC(T_CYC), .TONE_LEN(T_TONE), .DELAY_CYC(T_DLY), .PERIOD_CYC(T_PER),
             .HALF_CYC(T_HALF), .BIT_LOW(T_BL), .BIT_HIGH(T_BH)) dut (
      .SYS_CLK       (SYS_CLK),
      .RST           (RST),
      .COL_SENSE     (COL_SENSE),
      .BAUD_SEL      (BAUD_SEL),
      .ROW_DRIVE     (ROW_DRIVE),
      .VALID_N       (VALID_N),
      .BEEP_OUT      (BEEP_OUT),
      .SERIAL_TX_OUT (SERIAL_TX_OUT)
   );

   kme_keypad_model pad (
      .row_drive (ROW_DRIVE),
      .held      (held),
      .col_sense (COL_SENSE)
   );

   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end

   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
   end

   task automatic stop_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
      return {31'h0, v >= lo && v <= hi};
   endfunction

   // first closed key in scan order: lowest row, then lowest column
   function automatic logic [3:0] exp_key(input logic [15:0] m);
      for (int i = 15; i >= 0; i--) begin
         if (m[i]) begin
            exp_key = 4'(i);
         end
      end
   endfunction

   function automatic logic [7:0] exp_byte(input logic [3:0] k);
      return (k < 4'ha) ? 8'h30 + {4'h0, k} : 8'h37 + {4'h0, k};
   endfunction

   task automatic tick();
      @(posedge SYS_CLK);
      #1;
   endtask

   task automatic wait_valid(input logic lvl, output int n);
      n = 0;
      while (VALID_N !== lvl) begin
         tick();
         n++;
         if (n > 20000) begin
            n_fail++;
            stop_test();
         end
      end
   endtask

   task automatic idle_check(input int len);
      int bad;
      bad = 0;
      repeat (len) begin
         tick();
         if (ROW_DRIVE !== 4'hf || VALID_N !== 1'b1 || SERIAL_TX_OUT !== 1'b1) begin
            bad++;
         end
      end
      check(bad, 0);
   endtask

   task automatic press_check(input logic [15:0] mask, input logic b);
      int n;
      int c0;
      int tg;
      int bit_c;
      logic prev;
      logic [9:0] fr;
      bit_c = b ? T_BH : T_BL;
      BAUD_SEL = b;
      held = mask;
      c0 = cyc;
      wait_valid(1'b0, n);
      check(n, 1 + (SCAN_SETTLE_CYC + 1) * ((32'(exp_key(mask)) >> 2) + 1) + VALID_DELAY_CYC);
      check(ROW_DRIVE, exp_key(mask));
      held = 16'(~mask);
      n = 0;
      tg = 0;
      while (SERIAL_TX_OUT !== 1'b0 && n < T_TONE + 50) begin
         prev = BEEP_OUT;
         tick();
         n++;
         if (BEEP_OUT !== prev) begin
            tg++;
         end
      end
      check(in_rng(n, T_TONE, T_TONE + 4), 1);
      check(in_rng(tg, T_TONE / T_HALF - 2, T_TONE / T_HALF + 1), 1);
      check(VALID_N, 0);
      repeat (bit_c / 2) tick();
      for (int i = 0; i < 10; i++) begin
         fr[i] = SERIAL_TX_OUT;
         if (i < 9) begin
            repeat (bit_c) tick();
         end
      end
      check(fr[0], 0);
      check(fr[8:1], exp_byte(exp_key(mask)));
      check(fr[9], 1);
      check(ROW_DRIVE, exp_key(mask));
      held = 16'h0;
      wait_valid(1'b1, n);
      check(in_rng(cyc - c0, T_CYC - 3, T_CYC + 3), 1);
      idle_check(30);
   endtask

   initial begin
      int n;
      int c1;
      int c2;
      RST = 1'b1;
      BAUD_SEL = 1'b0;
      held = 16'h0;
      n_fail = 0;
      checks = 0;
      void'($urandom(32'h663c));
      repeat (6) @(posedge SYS_CLK);
      #1;
      RST = 1'b0;
      idle_check(200);
      for (int k = 0; k < 16; k++) begin
         press_check(16'h1 << k, 1'($urandom));
      end
      press_check(16'h20c0, 1'b0);
      press_check(16'($urandom) | 16'h8000, 1'b1);
      // contact opens before the scan reaches it
      held = 16'h0010;
      tick();
      held = 16'h0;
      n = 0;
      repeat (4 * (SCAN_SETTLE_CYC + 1)) begin
         tick();
         n += (VALID_N !== 1'b1);
      end
      check(n, 0);
      idle_check(400);
      // held key auto-repeats
      held = 16'h0020;
      BAUD_SEL = 1'b1;
      wait_valid(1'b0, n);
      c1 = cyc;
      wait_valid(1'b1, n);
      tick();
      check(ROW_DRIVE, 4'hf);
      wait_valid(1'b0, n);
      c2 = cyc;
      check(in_rng(c2 - c1, T_DLY - 3, T_DLY + 3), 1);
      check(ROW_DRIVE, 4'h5);
      wait_valid(1'b1, n);
      wait_valid(1'b0, n);
      check(in_rng(cyc - c2, T_PER - 3, T_PER + 3), 1);
      held = 16'h0;
      wait_valid(1'b1, n);
      idle_check(T_PER + 500);
      // reset in the middle of a byte
      held = 16'h0200;
      wait_valid(1'b0, n);
      repeat (T_TONE + 100) tick();
      RST = 1'b1;
      tick();
      check({ROW_DRIVE, VALID_N, BEEP_OUT, SERIAL_TX_OUT}, 32'h7d);
      held = 16'h0;
      RST = 1'b0;
      idle_check(100);
      stop_test();
   end
endmodule
